// ===== hdl/wake_lin_dev.sv
// Wake pin filter and transceiver mode control of the system basis chip.
// Assumes the host clears pin flags before Sleep and waits after commands.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module wake_lin_dev #(
  parameter int NUM_XCVR  = wake_lin_pkg::NUM_XCVR,
  parameter int FILT_CYC  = wake_lin_pkg::WAKE_FILT_CYC,
  parameter int BFILT_CYC = wake_lin_pkg::BUS_FILT_CYC
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  // Host link
  wake_lin_if.dev                  link,
  // Analog side
  input  wire logic                i_wake_input_pin,
  input  wire logic [NUM_XCVR-1:0] i_bus_dom,
  input  wire logic                i_uv_off,
  input  wire logic                i_fail_safe_req,
  // Transceiver controls
  output logic [2*NUM_XCVR-1:0]    o_xcvr_mode,
  output logic                     o_slope
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0]                pin_sync;
    logic [NUM_XCVR-1:0]       bus_s1;
    logic [NUM_XCVR-1:0]       bus_s2;
    logic                      pin_filt;
    logic [15:0]               pin_cnt;
    logic [NUM_XCVR-1:0][15:0] bus_cnt;
    logic                      en;
    logic                      mask_rise;
    logic                      mask_fall;
    logic                      mask_bus;
    logic                      flag_a;
    logic                      flag_b;
    logic [NUM_XCVR-1:0]       bus_flag;
    logic [NUM_XCVR-1:0]       bus_irq;
    logic [NUM_XCVR-1:0]       woke;
    logic [NUM_XCVR-1:0][1:0]  xm;
    logic                      slope;
    wake_lin_pkg::chip_mode_t  mode;
    logic [NUM_XCVR-1:0]       rxd_n;
    logic                      int_n;
    logic [7:0]                wsrc;
    logic [10:0]               status;
  } st_t;

  st_t s_r, s_nxt;

  function automatic logic is_active(wake_lin_pkg::chip_mode_t m);
    return m == wake_lin_pkg::CHIP_NORMAL || m == wake_lin_pkg::CHIP_STOP ||
           m == wake_lin_pkg::CHIP_FLASH;
  endfunction

  always_comb begin
    logic [3:0] op;
    logic [3:0] arg;
    logic       rise;
    logic       fall;
    logic       pin_ev;
    logic       bus_ev;
    int         sel;
    s_nxt  = s_r;
    op     = link.cmd_valid ? link.cmd[7:4] : wake_lin_pkg::OP_NOP;
    arg    = link.cmd[3:0];
    sel    = int'(arg[3:wake_lin_pkg::XCVR_SEL_POS]);
    rise   = 1'b0;
    fall   = 1'b0;
    bus_ev = 1'b0;
    s_nxt.pin_sync = {s_r.pin_sync[0], i_wake_input_pin};
    s_nxt.bus_s1   = i_bus_dom;
    s_nxt.bus_s2   = s_r.bus_s1;
    // Pin filter: level must differ for the whole window
    if (s_r.pin_sync[1] == s_r.pin_filt) begin
      s_nxt.pin_cnt = '0;
    end else if (s_r.pin_cnt == 16'(FILT_CYC - 1)) begin
      s_nxt.pin_cnt  = '0;
      s_nxt.pin_filt = s_r.pin_sync[1];
      rise = s_r.pin_sync[1];
      fall = ~s_r.pin_sync[1];
    end else begin
      s_nxt.pin_cnt = s_r.pin_cnt + 16'h0001;
    end
    pin_ev = (rise | fall) && s_r.mode != wake_lin_pkg::CHIP_OFF;
    // Commands
    unique case (op)
      wake_lin_pkg::OP_PIN_CFG: begin
        s_nxt.en        = arg[wake_lin_pkg::PIN_EN_POS];
        s_nxt.mask_rise = arg[wake_lin_pkg::MASK_RISE_POS];
        s_nxt.mask_fall = arg[wake_lin_pkg::MASK_FALL_POS];
        s_nxt.mask_bus  = arg[wake_lin_pkg::MASK_BUS_POS];
      end
      wake_lin_pkg::OP_CLR_FLAGS: begin
        s_nxt.flag_a   = 1'b0;
        s_nxt.flag_b   = 1'b0;
        s_nxt.bus_flag = '0;
        s_nxt.bus_irq  = '0;
        s_nxt.wsrc     = wake_lin_pkg::WAKE_SRC_RESET;
      end
      wake_lin_pkg::OP_SLOPE: begin
        if (s_r.mode == wake_lin_pkg::CHIP_NORMAL) begin
          s_nxt.slope = arg[0];
        end
      end
      wake_lin_pkg::OP_XCVR_MODE: begin
        if (sel < NUM_XCVR && s_r.mode != wake_lin_pkg::CHIP_FLASH &&
            s_r.mode != wake_lin_pkg::CHIP_FAILSAFE) begin
          unique case (arg[1:0])
            wake_lin_pkg::XM_WAKE: begin
              if (!s_r.woke[sel] && s_r.mode != wake_lin_pkg::CHIP_INIT) begin
                s_nxt.xm[sel] = wake_lin_pkg::XM_WAKE;
              end
            end
            wake_lin_pkg::XM_OFF: begin
              if (s_r.mode != wake_lin_pkg::CHIP_RESTART) begin
                s_nxt.xm[sel]   = wake_lin_pkg::XM_OFF;
                s_nxt.woke[sel] = 1'b0;
              end
            end
            default: begin
              if (s_r.mode == wake_lin_pkg::CHIP_NORMAL) begin
                s_nxt.xm[sel]    = arg[1:0];
                s_nxt.woke[sel]  = 1'b0;
                s_nxt.rxd_n[sel] = 1'b1;
              end
            end
          endcase
        end
      end
      wake_lin_pkg::OP_CHIP_MODE: begin
        if (arg[2:0] == 3'(wake_lin_pkg::CHIP_SLEEP) && (s_r.flag_a | s_r.flag_b)) begin
          s_nxt.mode = wake_lin_pkg::CHIP_RESTART;
        end else if (s_r.mode != wake_lin_pkg::CHIP_OFF) begin
          s_nxt.mode = wake_lin_pkg::chip_mode_t'(arg[2:0]);
        end
      end
      default: ;
    endcase
    // Bus wake detection per transceiver
    for (int i = 0; i < NUM_XCVR; i++) begin
      if (!s_r.bus_s2[i] || s_r.xm[i] != wake_lin_pkg::XM_WAKE || s_r.woke[i]) begin
        s_nxt.bus_cnt[i] = '0;
      end else if (s_r.bus_cnt[i] == 16'(BFILT_CYC - 1)) begin
        s_nxt.bus_cnt[i]  = '0;
        s_nxt.woke[i]     = 1'b1;
        s_nxt.bus_flag[i] = 1'b1;
        // Wakes out of quiet modes keep their flag but never interrupt
        if (is_active(s_r.mode)) s_nxt.bus_irq[i] = 1'b1;
        s_nxt.rxd_n[i]    = 1'b0;
        s_nxt.wsrc[wake_lin_pkg::WS_BUS_POS] = 1'b1;
        bus_ev = 1'b1;
      end else begin
        s_nxt.bus_cnt[i] = s_r.bus_cnt[i] + 16'h0001;
      end
    end
    // Pin wake reactions; set wins over clear
    if (pin_ev && s_r.en && is_active(s_r.mode)) begin
      if (rise) s_nxt.flag_a = 1'b1;
      if (fall) s_nxt.flag_b = 1'b1;
    end
    if (pin_ev && ((s_r.mode == wake_lin_pkg::CHIP_SLEEP && s_r.en) ||
                   s_r.mode == wake_lin_pkg::CHIP_FAILSAFE)) begin
      s_nxt.mode = wake_lin_pkg::CHIP_RESTART;
      s_nxt.wsrc[wake_lin_pkg::WS_PIN_POS] = 1'b1;
    end
    if (bus_ev && (s_r.mode == wake_lin_pkg::CHIP_SLEEP ||
                   s_r.mode == wake_lin_pkg::CHIP_FAILSAFE)) begin
      s_nxt.mode = wake_lin_pkg::CHIP_RESTART;
    end
    if (s_r.mode == wake_lin_pkg::CHIP_SLEEP && (s_r.flag_a | s_r.flag_b)) begin
      s_nxt.mode = wake_lin_pkg::CHIP_RESTART;
    end
    // Restart runs on to Normal once the wake is taken
    if (s_r.mode == wake_lin_pkg::CHIP_RESTART && op == wake_lin_pkg::OP_NOP) begin
      s_nxt.mode = wake_lin_pkg::CHIP_NORMAL;
    end
    if (i_uv_off) begin
      s_nxt.mode = wake_lin_pkg::CHIP_OFF;
    end else if (s_r.mode == wake_lin_pkg::CHIP_OFF) begin
      s_nxt.mode = wake_lin_pkg::CHIP_INIT;
    end else if (i_fail_safe_req) begin
      s_nxt.mode = wake_lin_pkg::CHIP_FAILSAFE;
    end
    // Automatic transceiver modes follow the chip mode
    for (int i = 0; i < NUM_XCVR; i++) begin
      if (s_nxt.mode == wake_lin_pkg::CHIP_FLASH) begin
        s_nxt.xm[i] = wake_lin_pkg::XM_NORMAL;
      end else if (s_nxt.mode == wake_lin_pkg::CHIP_FAILSAFE && !s_nxt.woke[i]) begin
        s_nxt.xm[i] = wake_lin_pkg::XM_WAKE;
      end else if (s_nxt.mode == wake_lin_pkg::CHIP_INIT) begin
        s_nxt.xm[i] = wake_lin_pkg::XM_OFF;
      end
    end
    // Interrupt only in modes that keep running; Restart holds it high
    s_nxt.int_n = ~(is_active(s_nxt.mode) &&
                    ((s_nxt.flag_a & ~s_nxt.mask_rise) |
                     (s_nxt.flag_b & ~s_nxt.mask_fall) |
                     ((|s_nxt.bus_irq) & ~s_nxt.mask_bus)));
    s_nxt.status = '0;
    s_nxt.status[wake_lin_pkg::ST_LEVEL_POS]  = is_active(s_nxt.mode) & s_nxt.pin_filt;
    s_nxt.status[wake_lin_pkg::ST_FLAG_A_POS] = s_nxt.flag_a;
    s_nxt.status[wake_lin_pkg::ST_FLAG_B_POS] = s_nxt.flag_b;
    s_nxt.status[wake_lin_pkg::ST_BUS_POS +: 3] = 3'(s_nxt.bus_flag);
    s_nxt.status[wake_lin_pkg::ST_SLOPE_POS]  = s_nxt.slope;
    s_nxt.status[wake_lin_pkg::ST_MODE_POS +: 3] = s_nxt.mode;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r       <= '0;
      s_r.slope <= wake_lin_pkg::SLOPE_LOW;
      s_r.mode  <= wake_lin_pkg::CHIP_INIT;
      s_r.rxd_n <= '1;
      s_r.int_n <= 1'b1;
      s_r.wsrc  <= wake_lin_pkg::WAKE_SRC_RESET;
      s_r.status[wake_lin_pkg::ST_MODE_POS +: 3] <= wake_lin_pkg::CHIP_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.status   = s_r.status;
  assign link.wake_src = s_r.wsrc;
  assign link.rxd_n    = 3'(s_r.rxd_n);
  assign link.int_n    = s_r.int_n;
  assign o_xcvr_mode   = s_r.xm;
  assign o_slope       = s_r.slope;
endmodule

// ===== shared/wake_lin_pkg.sv
// Shared constants and types for the wake pin and bus transceiver mode block.
// Assumes one 50 MHz clock on both ends; no imports, all uses are scoped.
package wake_lin_pkg;
  // ==========================================================================
  // Timing
  localparam int REF_CLK_MHZ        = 50;
  localparam int WAKE_FILT_MIN_US   = 10;
  localparam int WAKE_FILT_MAX_US   = 25;
  // Settle between min and max: 10 us rounded up, plus margin inside 25 us
  localparam int WAKE_FILT_CYC      = (WAKE_FILT_MIN_US * REF_CLK_MHZ) + 1;
  localparam int BUS_FILT_US        = 30;
  localparam int BUS_FILT_CYC       = BUS_FILT_US * REF_CLK_MHZ;
  localparam int NUM_XCVR           = 3;

  // ==========================================================================
  // Device command encoding (opcode in cmd[7:4], argument in cmd[3:0])
  localparam logic [3:0] OP_NOP       = 4'h0;
  localparam logic [3:0] OP_CHIP_MODE = 4'h1;
  localparam logic [3:0] OP_XCVR_MODE = 4'h2;
  localparam logic [3:0] OP_SLOPE     = 4'h3;
  localparam logic [3:0] OP_PIN_CFG   = 4'h4;
  localparam logic [3:0] OP_CLR_FLAGS = 4'h5;
  // Argument fields
  localparam int XCVR_SEL_POS  = 2;
  localparam int PIN_EN_POS    = 0;
  localparam int MASK_RISE_POS = 1;
  localparam int MASK_FALL_POS = 2;
  localparam int MASK_BUS_POS  = 3;

  // ==========================================================================
  // Status word (device to host), bit positions
  localparam int ST_LEVEL_POS  = 0;
  localparam int ST_FLAG_A_POS = 1;
  localparam int ST_FLAG_B_POS = 2;
  localparam int ST_BUS_POS    = 3;  // three bits, one per transceiver
  localparam int ST_SLOPE_POS  = 6;
  localparam int ST_MODE_POS   = 8;  // three bits

  // ==========================================================================
  // Wake source register at offset 0x0
  localparam logic [7:0] WAKE_SRC_OFS   = 8'h00;
  localparam logic [7:0] WAKE_SRC_RESET = 8'h00;
  localparam int WS_PIN_POS  = 0;
  localparam int WS_BUS_POS  = 1;

  // ==========================================================================
  // Host register offsets
  localparam logic [3:0] HR_CMD    = 4'h0;
  localparam logic [3:0] HR_STATUS = 4'h1;
  localparam logic [3:0] HR_WSRC   = 4'h2;
  localparam logic [3:0] HR_RXD    = 4'h3;

  typedef enum logic [2:0] {
    CHIP_INIT, CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP,
    CHIP_RESTART, CHIP_FAILSAFE, CHIP_FLASH, CHIP_OFF
  } chip_mode_t;

  typedef enum logic [1:0] {
    XM_OFF, XM_WAKE, XM_NORMAL, XM_RXONLY
  } xcvr_mode_t;

  localparam logic SLOPE_LOW    = 1'b0;
  localparam logic SLOPE_NORMAL = 1'b1;
endpackage

// ===== shared/wake_lin_if.sv
// Link between the wake/mode device and its host controller.
// Assumes both ends on the same clock; the bench joins them.
`timescale 1ns/100ps
interface wake_lin_if;
  logic       cmd_valid;
  logic [7:0] cmd;
  logic [10:0] status;
  logic [7:0] wake_src;
  logic [2:0] rxd_n;
  logic       int_n;
  modport dev  (input cmd_valid, input cmd, output status, output wake_src,
                output rxd_n, output int_n);
  modport host (output cmd_valid, output cmd, input status, input wake_src,
                input rxd_n, input int_n);
endinterface

// ===== hdl/wake_lin_host.sv
// Host controller end: software register port translated to device commands.
// Assumes software clears pin flags before issuing a Sleep command.
`timescale 1ns/100ps
module wake_lin_host (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // Software port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Device link
  wake_lin_if.host         link
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic        cmd_valid;
    logic [7:0]  cmd;
    logic [15:0] rdata;
  } st_t;

  st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd_valid = 1'b0;
    // One command per write; software orders flag clear before Sleep
    if (i_wr && i_addr == wake_lin_pkg::HR_CMD) begin
      s_nxt.cmd_valid = 1'b1;
      s_nxt.cmd       = i_wdata[7:0];
    end
    s_nxt.rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        wake_lin_pkg::HR_CMD:    s_nxt.rdata = {8'h00, s_r.cmd};
        wake_lin_pkg::HR_STATUS: s_nxt.rdata = {5'h00, link.status};
        wake_lin_pkg::HR_WSRC:   s_nxt.rdata = {8'h00, link.wake_src};
        wake_lin_pkg::HR_RXD:    s_nxt.rdata = {12'h000, link.int_n, link.rxd_n};
        default:                 s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.cmd_valid = s_r.cmd_valid;
  assign link.cmd       = s_r.cmd;
  assign o_rdata        = s_r.rdata;
endmodule

// ===== tb/wake_lin_monitor.sv
// Concurrent checks on the link between the wake/mode device and its host.
// Assumes the link signals of one interface, one clock and its async reset.
`timescale 1ns/100ps
module wake_lin_monitor (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // Link signals
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd,
  input  wire logic [10:0] status,
  input  wire logic [7:0]  wake_src,
  input  wire logic [2:0]  rxd_n,
  input  wire logic        int_n
);
  logic [2:0] mode;
  logic       slope_cmd;
  logic       pend;
  assign mode      = status[wake_lin_pkg::ST_MODE_POS +: 3];
  assign slope_cmd = cmd_valid && (cmd[7:4] == wake_lin_pkg::OP_SLOPE);
  assign pend      = status[wake_lin_pkg::ST_FLAG_A_POS] | status[wake_lin_pkg::ST_FLAG_B_POS];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================================
  // Sequences
  sequence sleep_exit_s;
    mode == wake_lin_pkg::CHIP_SLEEP ##1 mode == wake_lin_pkg::CHIP_RESTART;
  endsequence
  sequence sleep_pend_s;
    cmd_valid && cmd == {wake_lin_pkg::OP_CHIP_MODE, 4'h3} && pend;
  endsequence
  // ==========================================================================
  // Assertions
  slope_refused_a: assert property (slope_cmd && mode != wake_lin_pkg::CHIP_NORMAL
    |=> $stable(status[wake_lin_pkg::ST_SLOPE_POS])) else $error("slope changed");
  slope_taken_a: assert property (slope_cmd && mode == wake_lin_pkg::CHIP_NORMAL
    |=> ##1 status[wake_lin_pkg::ST_SLOPE_POS] == $past(cmd[0], 2)) else $error("slope lost");
  restart_exit_a: assert property (sleep_exit_s |=> mode == wake_lin_pkg::CHIP_NORMAL)
    else $error("no normal after restart");
  wake_quiet_a: assert property (sleep_exit_s |=> int_n)
    else $error("interrupt after sleep wake");
  sleep_rewake_a: assert property (sleep_pend_s |-> ##[1:4] mode == wake_lin_pkg::CHIP_RESTART)
    else $error("pending flag did not rewake");
  sleep_quiet_a: assert property (mode == wake_lin_pkg::CHIP_SLEEP
    && $past(mode) == wake_lin_pkg::CHIP_SLEEP |-> int_n) else $error("interrupt in sleep");
  rxd_flag_a: assert property ($fell(rxd_n[0]) |-> ##[0:1] status[wake_lin_pkg::ST_BUS_POS])
    else $error("receive low without flag");
  rxd_source_a: assert property ($fell(rxd_n[1]) |-> ##[0:1] wake_src[wake_lin_pkg::WS_BUS_POS])
    else $error("bus source not recorded");
  stop_stays_a: assert property ($fell(rxd_n[2]) && mode == wake_lin_pkg::CHIP_STOP
    |=> mode == wake_lin_pkg::CHIP_STOP [*3]) else $error("stop left on bus wake");
  level_hidden_a: assert property (!(mode inside {wake_lin_pkg::CHIP_NORMAL,
    wake_lin_pkg::CHIP_STOP, wake_lin_pkg::CHIP_FLASH}) |-> !status[wake_lin_pkg::ST_LEVEL_POS])
    else $error("level shown outside active modes");
  int_modes_a: assert property (!int_n && mode == $past(mode) |-> mode inside {
    wake_lin_pkg::CHIP_NORMAL, wake_lin_pkg::CHIP_STOP, wake_lin_pkg::CHIP_FLASH})
    else $error("interrupt in quiet mode");
endmodule

// ===== tb/wake_lin_pair_tb.sv
// Self-checking bench: host and device joined by their link interface.
// Assumes the software register port of the host is the only command path.
`timescale 1ns/100ps
module wake_pin_and_lin_mode_ctrl_tb;
  localparam int FC = 4;
  localparam int BF = 4;
  logic        clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic        pin = 1'b0;
  logic [2:0]  bus_dom = 3'h0;
  logic        uv = 1'b0;
  logic        fs = 1'b0;
  logic [5:0]  xm;
  logic        slope;
  logic [15:0] d;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #10 clk = ~clk;
  wake_lin_if link_if ();
  wake_lin_dev #(.FILT_CYC(FC), .BFILT_CYC(BF)) wake_lin_dev_i (
    .i_ref_clk(clk), .i_rst_b(i_rst_b), .link(link_if), .i_wake_input_pin(pin),
    .i_bus_dom(bus_dom), .i_uv_off(uv), .i_fail_safe_req(fs), .o_xcvr_mode(xm), .o_slope(slope));
  wake_lin_host wake_lin_host_i (
    .i_ref_clk(clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .link(link_if));
  wake_lin_monitor wake_lin_monitor_i (
    .i_ref_clk(clk), .i_rst_b(i_rst_b), .cmd_valid(link_if.cmd_valid), .cmd(link_if.cmd),
    .status(link_if.status), .wake_src(link_if.wake_src), .rxd_n(link_if.rxd_n),
    .int_n(link_if.int_n));
  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Command written, then time for link, device and status to settle
  task automatic cmd(input logic [3:0] op, input logic [3:0] arg);
    @(posedge clk);
    i_addr  <= wake_lin_pkg::HR_CMD;
    i_wdata <= {8'h00, op, arg};
    i_wr    <= 1'b1;
    @(posedge clk);
    i_wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic mode_is(input logic [2:0] m);
    rd(wake_lin_pkg::HR_STATUS);
    check("mode", d[10:8], m);
  endtask
  // Sync stages plus filter plus status lag
  task automatic set_pin(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (FC + 8) @(posedge clk);
  endtask
  task automatic bus(input int i);
    @(posedge clk);
    bus_dom[i] <= 1'b1;
    repeat (BF + 8) @(posedge clk);
    bus_dom[i] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    i_rst_b <= 1'b1;
    rd(wake_lin_pkg::HR_STATUS);
    check("reset status", d, 16'h0000);
    check("reset xcvr", {slope, xm, link_if.int_n, link_if.rxd_n}, 16'h000F);
    rd(4'hF);
    check("unmapped", d, 16'h0000);
    cmd(wake_lin_pkg::OP_CHIP_MODE, 4'h1);
    mode_is(wake_lin_pkg::CHIP_NORMAL);
    cmd(wake_lin_pkg::OP_SLOPE, 4'h1);
    check("slope", slope, 16'h0001);
    cmd(wake_lin_pkg::OP_PIN_CFG, 4'h1);
    set_pin(1'b1);
    rd(wake_lin_pkg::HR_STATUS);
    check("rise flags", d[2:0], 16'h0003);
    check("rise int", link_if.int_n, 16'h0000);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    set_pin(1'b0);
    rd(wake_lin_pkg::HR_STATUS);
    check("fall flags", d[2:0], 16'h0004);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    pin <= 1'b1;
    repeat (1) @(posedge clk);
    set_pin(1'b0);
    rd(wake_lin_pkg::HR_STATUS);
    check("glitch flags", d[2:0], 16'h0000);
    check("glitch int", link_if.int_n, 16'h0001);
    cmd(wake_lin_pkg::OP_PIN_CFG, 4'h3);
    set_pin(1'b1);
    rd(wake_lin_pkg::HR_STATUS);
    check("masked flag", d[1], 16'h0001);
    check("masked int", link_if.int_n, 16'h0001);
    // Flag left pending on purpose: sleep must bounce straight back
    cmd(wake_lin_pkg::OP_CHIP_MODE, 4'h3);
    mode_is(wake_lin_pkg::CHIP_NORMAL);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    cmd(wake_lin_pkg::OP_PIN_CFG, 4'h0);
    set_pin(1'b0);
    rd(wake_lin_pkg::HR_STATUS);
    check("pin disabled", d[2:1], 16'h0000);
    cmd(wake_lin_pkg::OP_XCVR_MODE, 4'h1);
    check("xcvr0 wake", xm[1:0], 16'h0001);
    bus(0);
    rd(wake_lin_pkg::HR_STATUS);
    check("normal bus", {d[10:8], d[3]}, 16'h0003);
    check("normal rxd int", {link_if.rxd_n, link_if.int_n}, 16'h000C);
    cmd(wake_lin_pkg::OP_XCVR_MODE, 4'h2);
    check("xcvr0 normal", {xm[1:0], link_if.rxd_n}, 16'h0017);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    cmd(wake_lin_pkg::OP_XCVR_MODE, 4'h5);
    cmd(wake_lin_pkg::OP_CHIP_MODE, 4'h3);
    mode_is(wake_lin_pkg::CHIP_SLEEP);
    bus(1);
    mode_is(wake_lin_pkg::CHIP_NORMAL);
    check("sleep rxd int", {link_if.rxd_n, link_if.int_n}, 16'h000B);
    rd(wake_lin_pkg::HR_WSRC);
    check("wake source", d[1], 16'h0001);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    cmd(wake_lin_pkg::OP_CHIP_MODE, 4'h2);
    cmd(wake_lin_pkg::OP_SLOPE, 4'h0);
    check("slope kept", slope, 16'h0001);
    cmd(wake_lin_pkg::OP_XCVR_MODE, 4'h9);
    bus(2);
    mode_is(wake_lin_pkg::CHIP_STOP);
    check("stop rxd int", {link_if.rxd_n[2], link_if.int_n}, 16'h0000);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    fs <= 1'b1;
    repeat (8) @(posedge clk);
    mode_is(wake_lin_pkg::CHIP_FAILSAFE);
    check("failsafe xcvr", xm[1:0], 16'h0001);
    @(posedge clk);
    fs <= 1'b0;
    set_pin(1'b1);
    mode_is(wake_lin_pkg::CHIP_NORMAL);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    cmd(wake_lin_pkg::OP_PIN_CFG, 4'h1);
    cmd(wake_lin_pkg::OP_CHIP_MODE, 4'h3);
    mode_is(wake_lin_pkg::CHIP_SLEEP);
    set_pin(1'b0);
    mode_is(wake_lin_pkg::CHIP_NORMAL);
    cmd(wake_lin_pkg::OP_CLR_FLAGS, 4'h0);
    // Supply gone: pin must be dead
    uv <= 1'b1;
    repeat (8) @(posedge clk);
    set_pin(1'b1);
    rd(wake_lin_pkg::HR_WSRC);
    check("off wake src", d[0], 16'h0000);
    rd(wake_lin_pkg::HR_STATUS);
    check("off flags", d[2:0], 16'h0000);
    end_of_test();
  end
endmodule
